// ===== core/sram64_host.sv
// host controller: turns single-word read/write requests into memory pin cycles
// assumes pin inputs synchronous to sys_clk_i; memory is the slowest speed grade
// pins change only on clock edges, so every memory timing is a whole number of cycles
`timescale 1ns/1ps
module sram64_host
   import sram64_pkg::*;
(
   // clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              sys_rst_i,
   // user request side
   input  wire logic              req_valid_i,
   input  wire logic              req_write_i,
   input  wire logic [ADDR_W-1:0] req_addr_i,
   input  wire logic              req_wdata_i,
   output logic                   req_ready_o,
   output logic                   rsp_valid_o,
   output logic                   rsp_rdata_o,
   // memory pins
   output logic [ADDR_W-1:0]      cell_address_o,
   output logic                   chip_sel_n_o,
   output logic                   write_n_o,
   output logic                   data_in_o,
   input  wire logic              data_out_i
);
   typedef struct packed {
      sram64_state_t     st;
      logic [CNT_W-1:0]  cnt;
      logic [ADDR_W-1:0] addr;
      logic              cs_n;
      logic              we_n;
      logic              din;
      logic              rv;
      logic              rd;
   } sram64_regs_t;

   sram64_regs_t s_reg;
   sram64_regs_t s_next;

   // handshake: a new request is taken only with the bus idle
   assign req_ready_o    = (s_reg.st == SR_IDLE);
   assign cell_address_o = s_reg.addr;
   assign chip_sel_n_o   = s_reg.cs_n;
   assign write_n_o      = s_reg.we_n;
   assign data_in_o      = s_reg.din;
   assign rsp_valid_o    = s_reg.rv;
   assign rsp_rdata_o    = s_reg.rd;

   // cycle sequencer
   always_comb begin
      s_next    = s_reg;
      s_next.rv = 1'b0;
      case (s_reg.st)
         SR_IDLE: begin
            if (req_valid_i) begin
               // address changes only with strobe high
               s_next.addr = req_addr_i;
               s_next.din  = req_wdata_i;
               s_next.cs_n = 1'b0;       // select with address, no setup needed
               if (req_write_i) begin
                  s_next.st  = SR_WSET;  // address setup before strobe
                  s_next.cnt = CNT_W'(AS_CYC);
               end else begin
                  s_next.st  = SR_RD;    // strobe held high for the read
                  s_next.cnt = CNT_W'(ACC_CYC);
               end
            end
         end
         SR_RD: begin
            // wait access time from select and address
            s_next.cnt = s_reg.cnt - CNT_ONE;
            if (s_reg.cnt == CNT_ONE) begin
               s_next.rv   = 1'b1;
               s_next.rd   = data_out_i;
               s_next.cs_n = 1'b1;       // deselect, device to standby
               s_next.st   = SR_REL;
               s_next.cnt  = CNT_W'(HZ_CYC);
            end
         end
         SR_WSET: begin
            // address setup cycles before the strobe falls
            s_next.cnt = s_reg.cnt - CNT_ONE;
            if (s_reg.cnt == CNT_ONE) begin
               s_next.we_n = 1'b0;       // write begins at strobe fall
               s_next.st   = SR_WPUL;
               s_next.cnt  = CNT_W'(WP_CYC);
            end
         end
         SR_WPUL: begin
            // pulse covers width, data setup and select-to-end
            s_next.cnt = s_reg.cnt - CNT_ONE;
            if (s_reg.cnt == CNT_ONE) begin
               s_next.we_n = 1'b1;       // strobe and select rise together to end the write and capture the bit
               s_next.cs_n = 1'b1;
               s_next.st   = SR_REL;
               s_next.cnt  = CNT_W'(((WR_CYC > HZ_CYC) ? WR_CYC : HZ_CYC));
            end
         end
         SR_REL: begin
            // address hold and output release before next cycle
            s_next.cnt = s_reg.cnt - CNT_ONE;
            if (s_reg.cnt == CNT_ONE) begin
               s_next.st = SR_IDLE;
            end
         end
         default: begin
            // a stray code goes back to idle
            s_next.st = SR_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s_reg.st   <= SR_IDLE;
         s_reg.cnt  <= CNT_ZERO;
         s_reg.addr <= '0;
         s_reg.cs_n <= 1'b1;
         s_reg.we_n <= 1'b1;
         s_reg.din  <= 1'b0;
         s_reg.rv   <= 1'b0;
         s_reg.rd   <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // checks on the pin sequence
   a_addr_stable_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (!write_n_o && !chip_sel_n_o) |=> $stable(cell_address_o) || write_n_o || chip_sel_n_o)
      else $error("address moved during write");
   a_read_strobe_high: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (s_reg.st == SR_RD) |-> write_n_o)
      else $error("strobe low during read");
   a_strobe_pulse_min: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $fell(write_n_o) |-> !write_n_o [*4])
      else $error("strobe pulse too short");
   a_addr_setup_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $fell(write_n_o) |-> $past(!chip_sel_n_o) && $stable(cell_address_o))
      else $error("no address setup before strobe");
   a_addr_hold_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(write_n_o) |-> $stable(cell_address_o) ##1 $stable(cell_address_o))
      else $error("address hold after write too short");
   a_select_before_end: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(write_n_o) |-> $past(!chip_sel_n_o, 4))
      else $error("select not low long enough before write end");
   a_read_after_access: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      rsp_valid_o |-> $past(!chip_sel_n_o, 7) && $past(!chip_sel_n_o, 2))
      else $error("read sampled before access time");
   a_data_setup_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(write_n_o) |-> $stable(data_in_o) && (data_in_o == $past(data_in_o, 3)))
      else $error("data changed near write end");

   // checks on reset, the idle bus and the address held while busy
   a_reset_idle_pins: assert property (@(posedge sys_clk_i)
      $fell(sys_rst_i)
      |-> chip_sel_n_o && write_n_o && !rsp_valid_o && req_ready_o)
      else $error("pins not idle after reset");
   a_idle_standby: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      req_ready_o
      |-> chip_sel_n_o && write_n_o)
      else $error("memory selected while idle");
   a_busy_addr_held: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !req_ready_o
      |=> $stable(cell_address_o))
      else $error("address moved while busy");
   a_take_to_pins: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (req_valid_i && req_ready_o)
      |=> !chip_sel_n_o && (cell_address_o == $past(req_addr_i)) && (data_in_o == $past(req_wdata_i)))
      else $error("request not placed on the pins");

   // checks on the write sequence and on the release gap after any cycle
   a_strobe_needs_select: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !write_n_o
      |-> !chip_sel_n_o)
      else $error("strobe low without select");
   a_select_before_strobe: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $fell(chip_sel_n_o)
      |-> write_n_o)
      else $error("strobe already low at select fall");
   a_data_held_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !write_n_o
      |=> $stable(data_in_o))
      else $error("data moved during strobe");
   a_write_ends_deselect: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(write_n_o)
      |-> chip_sel_n_o)
      else $error("select left low after write end");
   a_deselect_gap: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $fell(chip_sel_n_o)
      |-> $past(chip_sel_n_o, 2) && $past(chip_sel_n_o, 3) && $past(chip_sel_n_o, 4))
      else $error("select gap shorter than output release");
   a_ready_after_release: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(req_ready_o)
      |-> $past(chip_sel_n_o, 3))
      else $error("ready before output release time");

   // checks on the read sequence
   a_read_addr_steady: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (!chip_sel_n_o && write_n_o)
      |=> $stable(cell_address_o))
      else $error("address moved during access");
   a_read_strobe_span: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      rsp_valid_o
      |-> $past(write_n_o, 1) && $past(write_n_o, 4) && $past(write_n_o, 7))
      else $error("strobe dipped during read");
   a_rsp_deselects: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      rsp_valid_o
      |-> chip_sel_n_o)
      else $error("select left low after read");
   a_rsp_single_pulse: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      rsp_valid_o
      |=> !rsp_valid_o)
      else $error("read response longer than one cycle");
   a_rsp_bit_sampled: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      rsp_valid_o
      |-> (rsp_rdata_o == $past(data_out_i)))
      else $error("read bit not taken from the memory output");
   a_rdata_held: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !rsp_valid_o
      |=> $stable(rsp_rdata_o) || rsp_valid_o)
      else $error("read bit moved without a response");
endmodule

// ===== core/sram64_pkg.sv
// package for the host controller of a 64k x 1 asynchronous static memory
// assumes a 125 MHz system clock; timing figures use the slowest speed grade
package sram64_pkg;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned ADDR_W        = 16;
   // slowest grade figures in ns
   localparam int unsigned T_ACC_NS      = 55;  // address and select access
   localparam int unsigned T_AS_NS       = 5;   // address setup to strobe fall
   localparam int unsigned T_WP_NS       = 25;  // strobe pulse
   localparam int unsigned T_DW_NS       = 20;  // data setup to write end
   localparam int unsigned T_WR_NS       = 5;   // address hold after write
   localparam int unsigned T_HZ_NS       = 30;  // release after select rise
   // least times round up
   localparam int unsigned ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned AS_CYC  = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WP_CYC  = (((T_WP_NS > T_DW_NS) ? T_WP_NS : T_DW_NS) + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
   localparam int unsigned WR_CYC  = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HZ_CYC  = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W   = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

   typedef enum logic [4:0] {
      SR_IDLE  = 5'h01,
      SR_RD    = 5'h02,
      SR_WSET  = 5'h04,
      SR_WPUL  = 5'h08,
      SR_REL   = 5'h10
   } sram64_state_t;
endpackage

// ===== sim/sram64_mem_model.sv
// behavioural 64k x 1 static memory on the far side of the host controller
// assumes its pins come straight from the host; delays in ns
`timescale 1ns/1ps
module sram64_mem_model
   import sram64_pkg::*;
#(
   parameter int ACC_NS = 55
)(
   // memory pins
   input  wire logic [ADDR_W-1:0] cell_address_i,
   input  wire logic              chip_sel_n_i,
   input  wire logic              write_n_i,
   input  wire logic              data_in_i,
   output logic                   data_out_o
);
   logic cells [2**ADDR_W];  // kept without refresh
   logic wr_on = 1'b0;
   logic blk   = 1'b0;
   logic drv   = 1'b0;
   logic last  = 1'b0;
   int unsigned ticket = 0;
   // write runs while both low, bit taken at the first rising control
   always @(chip_sel_n_i, write_n_i) begin
      if (wr_on && (chip_sel_n_i || write_n_i)) cells[cell_address_i] = data_in_i;
      wr_on = !chip_sel_n_i && !write_n_i;
   end
   // strobe already low at select fall keeps the output off
   always @(chip_sel_n_i) begin
      blk = !chip_sel_n_i && !write_n_i;
   end
   // turn the output on after the access delay unless a newer select or strobe change came first
   task automatic arm_drive(input int unsigned t);
      #(ACC_NS);
      if (t == ticket) drv = 1'b1;
   endtask
   // drive after the access delay, whatever the deselect time; release at once
   // each change cancels a pending turn-on, so a write or deselect never drives late
   always @(chip_sel_n_i, write_n_i, blk) begin
      ticket = ticket + 1;
      drv    = 1'b0;
      if (!chip_sel_n_i && write_n_i && !blk) begin
         fork
            arm_drive(ticket);
         join_none
      end
   end
   // released line shows the inverse of the last bit, new cell shown at once
   assign data_out_o = drv ? cells[cell_address_i] : ~last;
   always @(data_out_o) begin
      if (drv) last = data_out_o;
   end
endmodule

// ===== sim/async_static_ram_64k_by_1_test.sv
// self-checking bench for the 64k x 1 memory host controller
// assumes the behavioural memory model on the pin side
`timescale 1ns/1ps
module async_static_ram_64k_by_1_test;
   import sram64_pkg::*;
   logic              sys_clk_i   = 1'b0;
   logic              sys_rst_i   = 1'b1;
   logic              req_valid_i = 1'b0;
   logic              req_write_i = 1'b0;
   logic [ADDR_W-1:0] req_addr_i  = 16'h0000;
   logic              req_wdata_i = 1'b0;
   logic              req_ready_o, rsp_valid_o, rsp_rdata_o, chip_sel_n_o, write_n_o, data_in_o, data_out_i;
   logic [ADDR_W-1:0] cell_address_o;
   int                n_errors    = 0;
   int                compares    = 0;
   sram64_host dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
      .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
      .cell_address_o(cell_address_o), .chip_sel_n_o(chip_sel_n_o), .write_n_o(write_n_o),
      .data_in_o(data_in_o), .data_out_i(data_out_i));
   sram64_mem_model mem (.cell_address_i(cell_address_o), .chip_sel_n_i(chip_sel_n_o),
      .write_n_i(write_n_o), .data_in_i(data_in_o), .data_out_o(data_out_i));
   // 125 MHz clock
   initial begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   // verdict and end of run
   task automatic tally_and_finish();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one comparison
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // bounded wait for the controller to go idle
   task automatic wait_ready();
      for (int n = 0; n < 20 && req_ready_o !== 1'b1; n++) begin
         @(posedge sys_clk_i);
         #1;
      end
      chk("ready", 16'(req_ready_o), 16'h0001);
      if (req_ready_o !== 1'b1) tally_and_finish();
   endtask
   // present one request, return at the edge that takes it
   task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic d);
      @(posedge sys_clk_i);
      req_valid_i <= 1'b1;
      req_write_i <= wr;
      req_addr_i  <= a;
      req_wdata_i <= d;
      @(posedge sys_clk_i);
      req_valid_i <= 1'b0;
   endtask
   // write: strobe low with select low, address and data steady
   task automatic do_wr(input logic [ADDR_W-1:0] a, input logic d);
      int low;
      low = 0;
      issue(1'b1, a, d);
      repeat (9) begin
         @(posedge sys_clk_i);
         #1;
         if (!write_n_o && !chip_sel_n_o && cell_address_o === a && data_in_o === d) low++;
      end
      chk("strobe cycles", 16'(low), 16'(WP_CYC));
      wait_ready();
   endtask
   // read: latency, bit and strobe held high
   task automatic do_rd(input logic [ADDR_W-1:0] a, input logic exp);
      int n;
      int bad;
      n = 0;
      bad = 0;
      issue(1'b0, a, 1'b0);
      do begin
         @(posedge sys_clk_i);
         #1;
         n++;
         if (write_n_o !== 1'b1) bad++;
      end while (rsp_valid_o !== 1'b1 && n < 20);
      chk("read latency", 16'(n), 16'(ACC_CYC));
      chk("read bit", 16'(rsp_rdata_o), 16'(exp));
      chk("strobe in read", 16'(bad), 16'h0000);
      if (rsp_valid_o !== 1'b1) tally_and_finish();
      @(posedge sys_clk_i);
      #1;
      chk("pulse end", 16'(rsp_valid_o), 16'h0000);
      wait_ready();
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      #1;
      chk("idle select", 16'(chip_sel_n_o), 16'h0001);
      do_wr(16'h0000, 1'b1);
      do_wr(16'hffff, 1'b0);
      do_wr(16'h8001, 1'b1);
      do_rd(16'h0000, 1'b1);
      do_rd(16'hffff, 1'b0);
      do_rd(16'h8001, 1'b1);
      do_wr(16'h8001, 1'b0);
      do_rd(16'h8001, 1'b0);
      tally_and_finish();
   end
endmodule
